// ==== esd_chan.sv ====
// one pwm channel output stage: forced level during shutdown while chan_en is set, resume at next counter zero
`timescale 1ns/100ps
module esd_chan
    import esd_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic force_act,
    input  wire logic arm,
    input  wire logic cnt_zero,
    input  wire logic chan_en,
    input  wire logic pwm_in,
    input  wire logic level,
    output logic      pwm_out_r,
    output logic      shut
);
    esd_ch_state_t state_r;
    esd_ch_state_t state_nxt;

    // next state; an active input always wins over arming or a counter zero
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ESD_CH_RUN: begin
                if (force_act) state_nxt = ESD_CH_HOLD;
            end
            ESD_CH_HOLD: begin
                if (!force_act && arm) state_nxt = ESD_CH_ARMED;
            end
            ESD_CH_ARMED: begin
                if (force_act) state_nxt = ESD_CH_HOLD;
                else if (cnt_zero) state_nxt = ESD_CH_RUN;
            end
            default: state_nxt = ESD_CH_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) state_r <= ESD_CH_RUN;
        else state_r <= state_nxt;
    end

    // output taken from the next state so forcing lands on the same edge
    always_ff @(posedge clk) begin
        if (reset) pwm_out_r <= 1'b0;
        else if (state_nxt != ESD_CH_RUN && chan_en) pwm_out_r <= level;
        else pwm_out_r <= pwm_in;
    end

    assign shut = (state_r != ESD_CH_RUN);
endmodule

// ==== esd_fault_src.sv ====
// external fault source model that drives the shutdown pin
`timescale 1ns/100ps
module esd_fault_src #(
    parameter int LAT = 2
) (
    clk,
    fault,
    active_high,
    pin
);
    input  wire logic clk;
    input  wire logic fault;
    input  wire logic active_high;
    output logic      pin;

    logic [7:0] dly_r = 8'h00;
    logic [8:0] line;

    //////////////////////////////////////////////////////////////////////////////
    // a delay line so the fault settles slowly, as a filtered board signal would
    always_ff @(posedge clk) begin
        dly_r <= {dly_r[6:0], fault};
    end

    // the fault maps onto the pin through the board polarity
    assign line = {dly_r, fault};
    assign pin  = active_high ? line[LAT] : ~line[LAT];
endmodule

// ==== esd_pkg.sv ====
// package: register map, field positions, reset values and channel state type for the emergency shutdown block
package esd_pkg;

    //////////////////////////////////////////////////////////////////////////////
    // register bus geometry and offsets
    localparam int          ESD_ADDR_W     = 4;
    localparam int          ESD_DATA_W     = 8;
    localparam logic [3:0]  ESD_CTRL_ADDR  = 4'h0;   // shutdown control/status register
    localparam logic [3:0]  ESD_STAT_ADDR  = 4'h1;   // sticky event status, write one to clear
    localparam logic [3:0]  ESD_MASK_ADDR  = 4'h2;   // event mask onto the interrupt line

    //////////////////////////////////////////////////////////////////////////////
    // field positions of the shutdown control register
    localparam int          ESD_FLAG_BIT   = 7;      // shutdown_change_flag
    localparam int          ESD_IE_BIT     = 6;      // shutdown_irq_enable
    localparam int          ESD_RSTRT_BIT  = 5;      // output_restart_trigger, reads zero
    localparam int          ESD_LVL_BIT    = 4;      // forced_output_level
    localparam int          ESD_PIN_BIT    = 2;      // shutdown_pin_state, read only
    localparam int          ESD_POL_BIT    = 1;      // shutdown_active_polarity
    localparam int          ESD_EN_BIT     = 0;      // emergency_shutdown_enable

    //////////////////////////////////////////////////////////////////////////////
    // event status layout, shared by status and mask registers
    localparam int          ESD_EV_W       = 2;
    localparam int          ESD_EV_CHANGE  = 0;      // shutdown input changed state
    localparam int          ESD_EV_RESUME  = 1;      // a channel left the forced state

    //////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0]  ESD_CTRL_RST   = 8'h00;
    localparam logic [1:0]  ESD_EV_RST     = 2'h0;

    //////////////////////////////////////////////////////////////////////////////
    // channel defaults
    localparam int          ESD_NUM_CH     = 6;
    localparam int          ESD_SHDN_CH    = 5;      // channel whose pin carries the shutdown input

    // per-channel output state
    typedef enum logic [1:0] {
        ESD_CH_RUN,
        ESD_CH_HOLD,
        ESD_CH_ARMED
    } esd_ch_state_t;

endpackage

// ==== esd_sync.sv ====
// two flip-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/100ps
module esd_sync
    import esd_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// ==== esd_tb_top.sv ====
// self-checking testbench for the emergency shutdown block
`timescale 1ns/100ps
module esd_tb_top;
    import esd_pkg::*;
    logic       clk, reset, wr, rd, fault, act_hi, irq, pin;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic [5:0] pwm_in, chan_en, cnt_zero, pwm_out, pwm_oe;
    int         errors, n_tests;

    esd_fault_src #(.LAT(2)) fsrc (.clk(clk), .fault(fault), .active_high(act_hi), .pin(pin));
    esd_top DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .irq(irq), .shutdown_input_pin(pin), .pwm_in(pwm_in), .chan_en(chan_en), .cnt_zero(cnt_zero),
        .pwm_out(pwm_out), .pwm_oe(pwm_oe));

    // 100 ns period clock
    always #50 clk = ~clk;

    //////////////////////////////////////////////////////////////////////////////
    // checking and bus tasks
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(nm, exp, rdata);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic zpulse(input logic [5:0] m);
        @(posedge clk);
        cnt_zero <= m;
        @(posedge clk);
        cnt_zero <= 6'h00;
        tick(1);
    endtask

    // bounded wait for the outputs, a timeout is a mismatch
    task automatic wait_out(input string nm, input logic [5:0] exp);
        int i;
        for (i = 0; i < 12 && pwm_out !== exp; i++) tick(1);
        chk(nm, {2'h0, exp}, {2'h0, pwm_out});
    endtask

    //////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        rchk("ctrl", ESD_CTRL_ADDR, 8'h00);
        rchk("stat", ESD_STAT_ADDR, 8'h00);
        rchk("mask", ESD_MASK_ADDR, 8'h00);
        rchk("unmapped", 4'hF, 8'h00);
        chk("oe", 8'h3F, {2'h0, pwm_oe});
        chk("out", {2'h0, pwm_in}, {2'h0, pwm_out});
        $display("test reset done");
    endtask

    // every control bit but enable and the change flag, then a fault: only the pin state bit may react
    task automatic t_disabled();
        wreg(ESD_CTRL_ADDR, 8'h7E);
        rchk("ctrl", ESD_CTRL_ADDR, 8'h52);
        fault <= 1'b1;
        tick(8);
        chk("out", {2'h0, pwm_in}, {2'h0, pwm_out});
        chk("irq", 8'h00, {7'h0, irq});
        rchk("ctrl", ESD_CTRL_ADDR, 8'h56);
        fault <= 1'b0;
        tick(6);
        $display("test disabled done");
    endtask

    task automatic t_force();
        wreg(ESD_CTRL_ADDR, 8'h53);
        tick(1);
        chk("oe", 8'h1F, {2'h0, pwm_oe});
        fault <= 1'b1;
        wait_out("forced", 6'h3E);
        tick(3);
        chk("irq", 8'h01, {7'h0, irq});
        rchk("ctrl", ESD_CTRL_ADDR, 8'hD7);
        wreg(ESD_CTRL_ADDR, 8'h73);
        zpulse(6'h3F);
        chk("out", 8'h3E, {2'h0, pwm_out});
        wreg(ESD_CTRL_ADDR, 8'hD3);
        tick(2);
        rchk("ctrl", ESD_CTRL_ADDR, 8'h57);
        chk("irq", 8'h00, {7'h0, irq});
        wreg(ESD_CTRL_ADDR, 8'h53);
        rchk("ctrl", ESD_CTRL_ADDR, 8'h57);
        fault <= 1'b0;
        tick(8);
        rchk("ctrl", ESD_CTRL_ADDR, 8'hD3);
        chk("out", 8'h3E, {2'h0, pwm_out});
        wreg(ESD_CTRL_ADDR, 8'hF3);
        tick(3);
        chk("out", 8'h3E, {2'h0, pwm_out});
        zpulse(6'h04);
        tick(1);
        chk("out", 8'h3A, {2'h0, pwm_out});
        zpulse(6'h3F);
        tick(1);
        chk("out", {2'h0, pwm_in}, {2'h0, pwm_out});
        $display("test force done");
    endtask

    task automatic t_status();
        rchk("stat", ESD_STAT_ADDR, 8'h03);
        wreg(ESD_CTRL_ADDR, 8'h01);
        tick(2);
        chk("irq", 8'h00, {7'h0, irq});
        wreg(ESD_MASK_ADDR, 8'h01);
        tick(2);
        chk("irq", 8'h01, {7'h0, irq});
        wreg(ESD_STAT_ADDR, 8'h01);
        tick(2);
        chk("irq", 8'h00, {7'h0, irq});
        rchk("stat", ESD_STAT_ADDR, 8'h02);
        wreg(ESD_STAT_ADDR, 8'h02);
        rchk("stat", ESD_STAT_ADDR, 8'h00);
        $display("test status done");
    endtask

    // active low input, forced low, then released by clearing enable and a counter zero
    task automatic t_pol_low();
        act_hi <= 1'b0;
        tick(6);
        wreg(ESD_CTRL_ADDR, 8'h01);
        fault <= 1'b1;
        wait_out("forced", 6'h00);
        wreg(ESD_CTRL_ADDR, 8'h80);
        tick(4);
        chk("out", 8'h00, {2'h0, pwm_out});
        chk("oe", 8'h3F, {2'h0, pwm_oe});
        zpulse(6'h3F);
        tick(1);
        chk("out", {2'h0, pwm_in}, {2'h0, pwm_out});
        $display("test polarity done");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    //////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        {wr, rd, fault, act_hi} = 4'b0001;
        addr = 4'h0;
        wdata = 8'h00;
        pwm_in = 6'h2A;
        chan_en = 6'h3E;
        cnt_zero = 6'h00;
        errors = 0;
        n_tests = 0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        tick(1);
        t_reset();
        t_disabled();
        t_force();
        t_status();
        t_pol_low();
        summarize();
    end
endmodule

// ==== esd_top.sv ====
// emergency shutdown control for a multi-channel pwm unit with register port and interrupt
//
// Operation
// - a change of the shutdown input in either direction sets the change flag
// - writing one clears the change flag; writing zero leaves it alone
// - with interrupt enable set, a set change flag raises the interrupt
// - restart is accepted only while the shutdown input is not active
// - after restart each channel resumes only at its next counter zero
// - clearing the enable also resumes channels only at counter zero, and only if the input is not active in the clearing cycle
// - the restart bit always reads as zero
// - active input drives every enabled channel at once to the forced level
// - the pin state bit reads the current level of the shutdown pin
// - polarity bit picks active low (0) or active high (1)
// - enable turns the shutdown pin into an input and arms the feature
// - all other control bits have no effect while enable is zero, except the flag clear and the level on channels still held or waiting for counter zero
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module esd_top
    import esd_pkg::*;
#(
    parameter int NUM_CH  = ESD_NUM_CH,
    parameter int SHDN_CH = ESD_SHDN_CH
) (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic [ESD_ADDR_W-1:0] addr,
    input  wire logic [ESD_DATA_W-1:0] wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output logic      [ESD_DATA_W-1:0] rdata,
    output logic                       irq,
    input  wire logic                  shutdown_input_pin,
    input  wire logic [NUM_CH-1:0]     pwm_in,
    input  wire logic [NUM_CH-1:0]     chan_en,
    input  wire logic [NUM_CH-1:0]     cnt_zero,
    output logic      [NUM_CH-1:0]     pwm_out,
    output logic      [NUM_CH-1:0]     pwm_oe
);

    // refuse geometries the channel indexing cannot serve
    initial begin
        if (NUM_CH < 1 || SHDN_CH < 0 || SHDN_CH >= NUM_CH) begin
            $error("esd_top: shutdown channel must lie inside the channel range");
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // declarations
    logic                  en_r;
    logic                  pol_r;
    logic                  lvl_r;
    logic                  ie_r;
    logic                  flag_r;
    logic [ESD_EV_W-1:0]   stat_r;
    logic [ESD_EV_W-1:0]   mask_r;
    logic [ESD_DATA_W-1:0] rdata_r;
    logic                  irq_r;
    logic [NUM_CH-1:0]     pwm_oe_r;
    logic                  act_d_r;
    logic [NUM_CH-1:0]     shut_d_r;
    logic                  pin_s;
    logic                  act;
    logic                  change_ev;
    logic                  resume_ev;
    logic [ESD_EV_W-1:0]   ev;
    logic                  wr_ctrl;
    logic                  wr_stat;
    logic                  wr_mask;
    logic                  arm;
    logic [NUM_CH-1:0]     shut_vec;
    logic [ESD_DATA_W-1:0] ctrl_view;

    //////////////////////////////////////////////////////////////////////////////
    // shutdown input conditioning
    // the pin is asynchronous; compare and edge detect only see the second stage
    esd_sync #(
        .WIDTH (1)
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     (shutdown_input_pin),
        .q     (pin_s)
    );

    // active only while the feature is armed, at the selected polarity
    assign act = en_r && (pin_s == pol_r);

    // previous active state for change detection
    always_ff @(posedge clk) begin
        if (reset) act_d_r <= 1'b0;
        else act_d_r <= act;
    end

    // either direction counts; disabling does not raise a spurious change
    assign change_ev = en_r && (act != act_d_r);

    //////////////////////////////////////////////////////////////////////////////
    // register decode
    assign wr_ctrl = wr && (addr == ESD_CTRL_ADDR);
    assign wr_stat = wr && (addr == ESD_STAT_ADDR);
    assign wr_mask = wr && (addr == ESD_MASK_ADDR);

    // restart is dropped silently while the input is still active
    // falling enable also arms, so outputs wait for counter zero
    assign arm = (wr_ctrl && en_r && wdata[ESD_RSTRT_BIT] && !act)
               || (wr_ctrl && en_r && !wdata[ESD_EN_BIT]);

    // plain control bits; bit 3 and the restart bit are never stored
    always_ff @(posedge clk) begin
        if (reset) begin
            en_r  <= ESD_CTRL_RST[ESD_EN_BIT];
            pol_r <= ESD_CTRL_RST[ESD_POL_BIT];
            lvl_r <= ESD_CTRL_RST[ESD_LVL_BIT];
            ie_r  <= ESD_CTRL_RST[ESD_IE_BIT];
        end else if (wr_ctrl) begin
            en_r  <= wdata[ESD_EN_BIT];
            pol_r <= wdata[ESD_POL_BIT];
            lvl_r <= wdata[ESD_LVL_BIT];
            ie_r  <= wdata[ESD_IE_BIT];
        end
    end

    // change flag: a change in the clearing cycle wins over the clear
    always_ff @(posedge clk) begin
        if (reset) flag_r <= ESD_CTRL_RST[ESD_FLAG_BIT];
        else if (change_ev) flag_r <= 1'b1;
        else if (wr_ctrl && wdata[ESD_FLAG_BIT]) flag_r <= 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////////
    // channel output stages, one per pwm channel
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            esd_chan u_chan (
                .clk       (clk),
                .reset     (reset),
                .force_act (act),
                .arm       (arm),
                .cnt_zero  (cnt_zero[gi]),
                .chan_en   (chan_en[gi]),
                .pwm_in    (pwm_in[gi]),
                .level     (lvl_r),
                .pwm_out_r (pwm_out[gi]),
                .shut      (shut_vec[gi])
            );

            // the shutdown pin is released to input while the feature is on
            always_ff @(posedge clk) begin
                if (reset) pwm_oe_r[gi] <= 1'b1;
                else pwm_oe_r[gi] <= !(en_r && (gi == SHDN_CH));
            end
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////////
    // event status and mask
    always_ff @(posedge clk) begin
        if (reset) shut_d_r <= '0;
        else shut_d_r <= shut_vec;
    end

    assign resume_ev = |(shut_d_r & ~shut_vec);
    assign ev[ESD_EV_CHANGE] = change_ev;
    assign ev[ESD_EV_RESUME] = resume_ev;

    // write one to clear; a new event in the same cycle survives
    always_ff @(posedge clk) begin
        if (reset) stat_r <= ESD_EV_RST;
        else if (wr_stat) stat_r <= (stat_r & ~wdata[ESD_EV_W-1:0]) | ev;
        else stat_r <= stat_r | ev;
    end

    always_ff @(posedge clk) begin
        if (reset) mask_r <= ESD_EV_RST;
        else if (wr_mask) mask_r <= wdata[ESD_EV_W-1:0];
    end

    // one level interrupt; nothing reaches it while the feature is off
    always_ff @(posedge clk) begin
        if (reset) irq_r <= 1'b0;
        else irq_r <= en_r && ((flag_r && ie_r) || (|(stat_r & mask_r)));
    end

    //////////////////////////////////////////////////////////////////////////////
    // read path, data valid the cycle after the strobe only
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[ESD_FLAG_BIT] = flag_r;
        ctrl_view[ESD_IE_BIT]   = ie_r;
        ctrl_view[ESD_LVL_BIT]  = lvl_r;
        ctrl_view[ESD_PIN_BIT]  = pin_s;
        ctrl_view[ESD_POL_BIT]  = pol_r;
        ctrl_view[ESD_EN_BIT]   = en_r;
    end

    // unmapped addresses and idle cycles read zero
    always_ff @(posedge clk) begin
        if (reset) rdata_r <= 8'h00;
        else if (rd) begin
            case (addr)
                ESD_CTRL_ADDR: rdata_r <= ctrl_view;
                ESD_STAT_ADDR: rdata_r <= {6'h00, stat_r};
                ESD_MASK_ADDR: rdata_r <= {6'h00, mask_r};
                default:       rdata_r <= 8'h00;
            endcase
        end else rdata_r <= 8'h00;
    end

    assign rdata  = rdata_r;
    assign irq    = irq_r;
    assign pwm_oe = pwm_oe_r;

    //////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_flag_set;
        change_ev |=> flag_r;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("change did not set the flag");

    property p_flag_clr;
        wr_ctrl && wdata[ESD_FLAG_BIT] && !change_ev |=> !flag_r;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("write one did not clear the flag");

    property p_flag_keep;
        wr_ctrl && !wdata[ESD_FLAG_BIT] && flag_r |=> flag_r;
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("write zero disturbed the flag");

    property p_irq;
        en_r && ie_r && flag_r |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("enabled flag gave no interrupt");

    property p_refuse;
        act |=> &shut_vec;
    endproperty
    a_refuse: assert property (p_refuse) else $error("channel ran while input active");

    property p_resume_zero;
        $fell(shut_vec[0]) |-> $past(cnt_zero[0]) && !$past(act);
    endproperty
    a_resume_zero: assert property (p_resume_zero) else $error("resume outside counter zero");

    property p_restart_reads_zero;
        $past(rd) |-> !rdata[ESD_RSTRT_BIT] && !rdata[3];
    endproperty
    a_restart_reads_zero: assert property (p_restart_reads_zero) else $error("restart bit read high");

    property p_force;
        $rose(shut_vec[1]) && $past(chan_en[1]) |-> pwm_out[1] == $past(lvl_r);
    endproperty
    a_force: assert property (p_force) else $error("output not forced to level");

    property p_pin_state;
        $past(rd) && ($past(addr) == ESD_CTRL_ADDR) |-> rdata[ESD_PIN_BIT] == $past(pin_s);
    endproperty
    a_pin_state: assert property (p_pin_state) else $error("pin state bit wrong");

    property p_polarity;
        en_r && (pin_s == pol_r) |=> act_d_r;
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity not honoured");

    property p_pin_input;
        en_r |=> !pwm_oe[SHDN_CH];
    endproperty
    a_pin_input: assert property (p_pin_input) else $error("shutdown pin still driven");

    property p_disabled;
        !en_r |-> !change_ev ##1 !irq;
    endproperty
    a_disabled: assert property (p_disabled) else $error("activity while disabled");

    // status bookkeeping, hold and resume checks
    property p_stat_set;
        ev[ESD_EV_CHANGE] |=> stat_r[ESD_EV_CHANGE];
    endproperty
    a_stat_set: assert property (p_stat_set) else $error("change not recorded in status");

    property p_stat_clear;
        wr_stat && wdata[ESD_EV_CHANGE] && !change_ev |=> !stat_r[ESD_EV_CHANGE];
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("status write one did not clear");

    property p_irq_off;
        !ie_r && !(|(stat_r & mask_r)) |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt without an enabled source");

    property p_refuse_arm;
        wr_ctrl && act && wdata[ESD_EN_BIT] |-> !arm;
    endproperty
    a_refuse_arm: assert property (p_refuse_arm) else $error("restart armed while input active");

    property p_hold_until_zero;
        shut_vec[1] && !cnt_zero[1] |=> shut_vec[1];
    endproperty
    a_hold_until_zero: assert property (p_hold_until_zero) else $error("channel left hold early");

    property p_resume_set;
        resume_ev |=> stat_r[ESD_EV_RESUME];
    endproperty
    a_resume_set: assert property (p_resume_set) else $error("resume not recorded in status");

    property p_run_follow;
        !act && !shut_vec[2] |=> pwm_out[2] == $past(pwm_in[2]);
    endproperty
    a_run_follow: assert property (p_run_follow) else $error("running channel not following");

    property p_disable_arms;
        wr_ctrl && en_r && !wdata[ESD_EN_BIT] && shut_vec[1] |=> shut_vec[1];
    endproperty
    a_disable_arms: assert property (p_disable_arms) else $error("disable resumed at once");

    property p_level_follow;
        act && chan_en[1] |=> pwm_out[1] == $past(lvl_r);
    endproperty
    a_level_follow: assert property (p_level_follow) else $error("enabled channel not at level");

    property p_polarity_low;
        en_r && !pol_r && !pin_s |-> act;
    endproperty
    a_polarity_low: assert property (p_polarity_low) else $error("low input not active");

    property p_oe_release;
        !en_r |=> pwm_oe[SHDN_CH];
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("shutdown pin not driven when off");

    property p_no_force_disabled;
        !en_r |-> !act;
    endproperty
    a_no_force_disabled: assert property (p_no_force_disabled) else $error("forcing while off");

    c_shutdown: cover property ($rose(act));
    c_restart:  cover property (arm ##[1:50] $fell(shut_vec[0]));
    c_irq:      cover property ($rose(irq));
    c_refused:  cover property (wr_ctrl && wdata[ESD_RSTRT_BIT] && act);
    c_dis_arm:  cover property (wr_ctrl && en_r && !wdata[ESD_EN_BIT] && shut_vec[1]);

endmodule
